// file: common/pidos_pkg.sv
// Shared constants, register map and types of the PID output stage
package pidos_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SAMPLE_TIME_US = 100;
  localparam int unsigned SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_TIME_US;
  localparam longint unsigned PULSE_PERIOD_S = 60;
  localparam int unsigned PULSE_CYC = 32'(PULSE_PERIOD_S * 64'(CLK_HZ));
  // Number formats: value 1.0 (100 %) is 2**ONE_SHIFT, accumulators carry ACC_FRAC more bits
  localparam int ONE_SHIFT = 14;
  localparam int ACC_FRAC = 16;
  localparam int ACC_W = 48;
  localparam int COEF_SHIFT = 8;
  localparam logic [15:0] VAL_ONE = 16'h4000;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_GAIN = 8'h08;
  localparam logic [7:0] REG_KI = 8'h0C;
  localparam logic [7:0] REG_KD = 8'h10;
  localparam logic [7:0] REG_LAG = 8'h14;
  localparam logic [7:0] REG_DBAND = 8'h18;
  localparam logic [7:0] REG_LIMIT = 8'h1C;
  localparam logic [7:0] REG_OPPT = 8'h20;
  localparam logic [7:0] REG_MANUAL = 8'h24;
  localparam logic [7:0] REG_SAMPLE = 8'h28;
  localparam logic [7:0] REG_PERIOD = 8'h2C;
  localparam logic [7:0] REG_SPA_IN = 8'h30;
  localparam logic [7:0] REG_SPA_MAP = 8'h34;
  localparam logic [7:0] REG_SPB_IN = 8'h38;
  localparam logic [7:0] REG_SPB_MAP = 8'h3C;
  localparam logic [7:0] REG_LMN = 8'h40;
  localparam logic [7:0] REG_OUTAB = 8'h44;
  // Field positions
  localparam int CTRL_W = 10;
  localparam int CTRL_SOFT_BIT = 10;
  // Reset values
  localparam logic [15:0] GAIN_RST = 16'h0100;
  localparam logic [15:0] COEF_RST = 16'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [31:0] PAIR_RST = 32'h4000_0000;
  // Types
  typedef logic signed [ACC_W-1:0] pidos_acc_t;
  typedef enum logic [1:0] {AO_ZERO, AO_A, AO_B, AO_AIN} pidos_ao_t;
  typedef enum logic [1:0] {PM_CONT, PM_TWO, PM_THREE} pidos_pmode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_OUT} pidos_state_t;
  typedef struct packed {
    pidos_ao_t ao1_src;
    pidos_ao_t ao0_src;
    pidos_pmode_t pmode;
    logic auto_op;
    logic p_sel;
    logic bumpless;
    logic auto_mode;
  } pidos_ctrl_t;
  // Limits: hi/lo; split input: end/start; split map: slope/out start
  typedef struct packed {
    logic signed [15:0] hi;
    logic signed [15:0] lo;
  } pidos_pair_t;
endpackage

// file: hw/pidos_pulse.sv
// Period-based duty-cycle generator for one binary controller output
`timescale 1ns/1ps
module pidos_pulse (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire logic enable,
  input wire logic [31:0] period,
  input wire logic signed [15:0] duty,
  // Binary output
  output logic pulse
);
  import pidos_pkg::*;

  logic [31:0] cnt_q;
  logic [31:0] on_q;
  logic pulse_q;

  ////////////////////////////////////////////////////////////////////////////
  wire [31:0] last = (period == '0) ? '0 : period - 32'd1;
  wire [15:0] duty_c = duty[15] ? '0 : (duty > $signed(VAL_ONE)) ? VAL_ONE : duty;
  wire [47:0] on_prod = 48'(period) * 48'(duty_c);
  wire [31:0] on_calc = 32'(on_prod >> ONE_SHIFT);
  wire wrap = cnt_q >= last;
  wire [31:0] cnt_d = wrap ? '0 : cnt_q + 32'd1;
  // Duty is sampled once per period so a mid-period change never splits a pulse
  wire [31:0] on_d = wrap ? on_calc : on_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      on_q <= '0;
      pulse_q <= 1'b0;
    end else if (!enable) begin
      cnt_q <= last;
      on_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      on_q <= on_d;
      pulse_q <= cnt_d < on_d;
    end
  end

  assign pulse = pulse_q;

  ////////////////////////////////////////////////////////////////////////////
  AST_PULSE_WIDTH: assert property (
    @(posedge clk) disable iff (rst) pulse_q |-> (cnt_q < on_q))
    else $error("pulse high past its on time");
endmodule // pidos_pulse

// file: hw/pidos_top.sv
// PID controller core with dead band, limiting, split range and pulse outputs
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - PI mode: no derivative; integrator acts until error is zero, within limits.
// - Beyond either output limit, the integral term holds its value; the code holds only a step pushing further past the limit.
// - Bumpless: integrator tracks in manual so changeover has no P or D step.
// - Not bumpless: changeover steps from manual value by the present error.
// - Proportional path can be switched off by its select flag.
// - PD mode: no integral, zero error gives zero unless operating point.
// - Automatic operating point loads the manual value at manual-to-auto switch.
// - Fixed operating point uses the software constant instead.
// - Integral and derivative use trapezoid discretisation with wide arithmetic.
// - Derivative path has a first-order lag with configurable time constant.
// - PID mode sums P, I and D, all fed in parallel by the error.
// - Dead band sits ahead of every controller path.
// - Inside the band output is zero; outside it follows, offset by the width.
// - Manipulated value is always clamped between upper and lower limits.
// - Split range derives scaled outputs A and B from the manipulated value.
// - Correction keeps output unchanged at changeover; not for fixed-point P.
// - Each analog output selects A, B or the conditioned analog input.
// - Two-step: output A pulses high for fraction A of each period.
// - Three-step: output B pulses a second output the same way.
// - Manipulated value recomputed once per sampling period, parallel structure.
// - Zero reset or derivative coefficient disables that component.
// - Negative gain reverses the control direction; the code applies the gain to the P term only, so I and D keep their direction.
////////////////////////////////////////////////////////////////////////////////
module pidos_top #(
  parameter int unsigned SAMPLE_CYC_DEF = pidos_pkg::SAMPLE_CYC,
  parameter int unsigned PULSE_CYC_DEF = pidos_pkg::PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Conditioned process values
  input wire logic signed [15:0] error_signal,
  input wire logic signed [15:0] ain_value,
  // Controller outputs
  output logic signed [15:0] manipulated_value,
  output logic signed [15:0] out_a,
  output logic signed [15:0] out_b,
  output logic signed [15:0] ao0,
  output logic signed [15:0] ao1,
  output logic heat_pulse,
  output logic cool_pulse
);
  import pidos_pkg::*;

  function automatic logic signed [15:0] split_map(input logic signed [15:0] v,
                                                   input pidos_pair_t span,
                                                   input pidos_pair_t map);
    logic signed [15:0] c;
    logic signed [32:0] prod;
    c = v;
    if (v < span.lo) begin
      c = span.lo;
    end else if (v > span.hi) begin
      c = span.hi;
    end
    prod = (33'(c) - 33'(span.lo)) * 33'(map.hi);
    return 16'(33'(map.lo) + (prod >>> ONE_SHIFT));
  endfunction

  function automatic logic signed [15:0] ao_pick(input pidos_ao_t s,
                                                 input logic signed [15:0] a,
                                                 input logic signed [15:0] b,
                                                 input logic signed [15:0] x);
    case (s)
      AO_A: return a;
      AO_B: return b;
      AO_AIN: return x;
      default: return '0;
    endcase
  endfunction

  // Configuration registers
  pidos_ctrl_t ctrl_q;
  logic soft_q;
  logic signed [15:0] gain_q;
  logic [15:0] ki_q;
  logic [15:0] kd_q;
  logic [15:0] lag_q;
  logic signed [15:0] dband_q;
  logic signed [15:0] op_q;
  logic signed [15:0] manual_q;
  logic [31:0] samp_per_q;
  logic [31:0] pulse_per_q;
  pidos_pair_t lim_q;
  pidos_pair_t spa_in_q;
  pidos_pair_t spa_map_q;
  pidos_pair_t spb_in_q;
  pidos_pair_t spb_map_q;
  // Bus state
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // Controller state
  pidos_state_t st_q;
  pidos_state_t st_d;
  logic [31:0] samp_cnt_q;
  logic tick_q;
  logic signed [16:0] e_q;
  logic signed [16:0] e_prev_q;
  pidos_acc_t p_q;
  pidos_acc_t inc_q;
  pidos_acc_t d_q;
  pidos_acc_t integ_q;
  logic signed [15:0] op_cap_q;
  logic signed [15:0] lmn_q;
  logic signed [15:0] a_q;
  logic signed [15:0] b_q;
  logic hi_hit_q;
  logic lo_hit_q;
  logic signed [15:0] ao0_q;
  logic signed [15:0] ao1_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire req = read | write;
  wire wr_go = write & ~wait_q;
  wire sel_ctrl = address == REG_CTRL;
  wire sel_gain = address == REG_GAIN;
  wire sel_ki = address == REG_KI;
  wire sel_kd = address == REG_KD;
  wire sel_lag = address == REG_LAG;
  wire sel_dband = address == REG_DBAND;
  wire sel_limit = address == REG_LIMIT;
  wire sel_oppt = address == REG_OPPT;
  wire sel_manual = address == REG_MANUAL;
  wire sel_sample = address == REG_SAMPLE;
  wire sel_period = address == REG_PERIOD;
  wire sel_spa_in = address == REG_SPA_IN;
  wire sel_spa_map = address == REG_SPA_MAP;
  wire sel_spb_in = address == REG_SPB_IN;
  wire sel_spb_map = address == REG_SPB_MAP;

  always_comb begin
    if (sel_ctrl) rdata_d = 32'(ctrl_q);
    else if (address == REG_STATUS) rdata_d = {28'h000_0000, st_q != ST_IDLE, lo_hit_q,
                                              hi_hit_q, ctrl_q.auto_mode};
    else if (sel_gain) rdata_d = 32'(unsigned'(gain_q));
    else if (sel_ki) rdata_d = 32'(ki_q);
    else if (sel_kd) rdata_d = 32'(kd_q);
    else if (sel_lag) rdata_d = 32'(lag_q);
    else if (sel_dband) rdata_d = 32'(unsigned'(dband_q));
    else if (sel_limit) rdata_d = lim_q;
    else if (sel_oppt) rdata_d = 32'(unsigned'(op_q));
    else if (sel_manual) rdata_d = 32'(unsigned'(manual_q));
    else if (sel_sample) rdata_d = samp_per_q;
    else if (sel_period) rdata_d = pulse_per_q;
    else if (sel_spa_in) rdata_d = spa_in_q;
    else if (sel_spa_map) rdata_d = spa_map_q;
    else if (sel_spb_in) rdata_d = spb_in_q;
    else if (sel_spb_map) rdata_d = spb_map_q;
    else if (address == REG_LMN) rdata_d = 32'(unsigned'(lmn_q));
    else if (address == REG_OUTAB) rdata_d = {b_q, a_q};
    else rdata_d = '0;
  end

  // One wait cycle per access, then a one-cycle completion; back-to-back works
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
      soft_q <= 1'b0;
      gain_q <= GAIN_RST;
      ki_q <= COEF_RST;
      kd_q <= COEF_RST;
      lag_q <= COEF_RST;
      dband_q <= VAL_RST;
      op_q <= VAL_RST;
      manual_q <= VAL_RST;
      samp_per_q <= SAMPLE_CYC_DEF;
      pulse_per_q <= PULSE_CYC_DEF;
      lim_q <= PAIR_RST;
      spa_in_q <= PAIR_RST;
      spa_map_q <= PAIR_RST;
      spb_in_q <= PAIR_RST;
      spb_map_q <= PAIR_RST;
    end else begin
      soft_q <= wr_go & sel_ctrl & writedata[CTRL_SOFT_BIT];
      if (wr_go & sel_ctrl) ctrl_q <= pidos_ctrl_t'(writedata[CTRL_W-1:0]);
      if (wr_go & sel_gain) gain_q <= writedata[15:0];
      if (wr_go & sel_ki) ki_q <= writedata[15:0];
      if (wr_go & sel_kd) kd_q <= writedata[15:0];
      if (wr_go & sel_lag) lag_q <= writedata[15:0];
      if (wr_go & sel_dband) dband_q <= writedata[15:0];
      if (wr_go & sel_limit) lim_q <= writedata;
      if (wr_go & sel_oppt) op_q <= writedata[15:0];
      if (wr_go & sel_manual) manual_q <= writedata[15:0];
      if (wr_go & sel_sample) samp_per_q <= writedata;
      if (wr_go & sel_period) pulse_per_q <= writedata;
      if (wr_go & sel_spa_in) spa_in_q <= writedata;
      if (wr_go & sel_spa_map) spa_map_q <= writedata;
      if (wr_go & sel_spb_in) spb_in_q <= writedata;
      if (wr_go & sel_spb_map) spb_map_q <= writedata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampling tick
  wire samp_wrap = (samp_per_q <= 32'd1) | (samp_cnt_q >= samp_per_q - 32'd1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      samp_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      samp_cnt_q <= samp_wrap ? '0 : samp_cnt_q + 32'd1;
      tick_q <= samp_wrap;
    end
  end

  always_comb begin
    case (st_q)
      ST_IDLE: st_d = tick_q ? ST_CALC : ST_IDLE;
      ST_CALC: st_d = ST_OUT;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) st_q <= ST_IDLE;
    else st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dead band ahead of all paths; the fixed offset outside avoids a jump at the edge
  wire signed [16:0] err_x = 17'(error_signal);
  wire signed [16:0] band = 17'(dband_q);
  wire signed [16:0] db_val = (err_x > band) ? err_x - band :
                              (err_x < -band) ? err_x + band : '0;

  // Parallel terms, all in accumulator units
  wire signed [17:0] e_sum = 18'(e_q) + 18'(e_prev_q);
  wire signed [17:0] e_dif = 18'(e_q) - 18'(e_prev_q);
  // Signed gain: a negative value turns the direction of action round
  wire pidos_acc_t p_calc = ctrl_q.p_sel ?
                            ACC_W'(gain_q * e_q) <<< COEF_SHIFT : '0;
  // Trapezoid: coefficient is sampling time over twice the reset time
  wire pidos_acc_t inc_calc = ACC_W'($signed({1'b0, ki_q}) * e_sum);
  wire signed [64:0] lag_prod = $signed({1'b0, lag_q}) * d_q;
  wire pidos_acc_t d_calc = (kd_q == '0) ? '0 :
                            ACC_W'(lag_prod >>> ACC_FRAC) +
                            (ACC_W'($signed({1'b0, kd_q}) * e_dif) <<< COEF_SHIFT);

  // Operating point stands in for the integrator when the reset coefficient is zero
  wire signed [15:0] op_sel = ctrl_q.auto_op ? op_cap_q : op_q;
  wire pidos_acc_t op_acc = ACC_W'(op_sel) <<< ACC_FRAC;
  wire pidos_acc_t i_term = (ki_q == '0) ? op_acc : integ_q;
  wire pidos_acc_t sum = p_q + i_term + d_q;
  wire signed [15:0] lim_hi = lim_q.hi;
  wire signed [15:0] lim_lo = lim_q.lo;
  wire pidos_acc_t hi_acc = ACC_W'(lim_hi) <<< ACC_FRAC;
  wire pidos_acc_t lo_acc = ACC_W'(lim_lo) <<< ACC_FRAC;
  wire over_hi = sum > hi_acc;
  wire under_lo = sum < lo_acc;
  // Hold only a step that pushes further past a limit, so a reversed error unwinds at once
  wire wind_hold = (over_hi & ~inc_q[ACC_W-1]) | (under_lo & inc_q[ACC_W-1]);
  wire signed [15:0] auto_val = over_hi ? lim_hi :
                                under_lo ? lim_lo : 16'(sum >>> ACC_FRAC);
  wire signed [15:0] man_val = (manual_q > lim_hi) ? lim_hi :
                               (manual_q < lim_lo) ? lim_lo : manual_q;
  wire signed [15:0] lmn_d = ctrl_q.auto_mode ? auto_val : man_val;
  wire pidos_acc_t man_acc = ACC_W'(man_val) <<< ACC_FRAC;
  // Bumpless leaves out P and D so automatic starts where manual stood
  wire pidos_acc_t track = ctrl_q.bumpless ? man_acc - p_q - d_q : man_acc;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      e_q <= '0;
      e_prev_q <= '0;
      p_q <= '0;
      inc_q <= '0;
      d_q <= '0;
      integ_q <= '0;
      op_cap_q <= '0;
    end else if (soft_q) begin
      e_q <= '0;
      e_prev_q <= '0;
      p_q <= '0;
      inc_q <= '0;
      d_q <= '0;
      integ_q <= '0;
      op_cap_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (tick_q) begin
            e_prev_q <= e_q;
            e_q <= db_val;
          end
        end
        ST_CALC: begin
          p_q <= p_calc;
          inc_q <= inc_calc;
          d_q <= d_calc;
        end
        ST_OUT: begin
          if (ctrl_q.auto_mode) begin
            if (!wind_hold) integ_q <= integ_q + inc_q;
          end else begin
            integ_q <= track;
            op_cap_q <= man_val;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage
  wire signed [15:0] a_d = split_map(lmn_d, spa_in_q, spa_map_q);
  wire signed [15:0] b_d = split_map(lmn_d, spb_in_q, spb_map_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lmn_q <= '0;
      a_q <= '0;
      b_q <= '0;
      hi_hit_q <= 1'b0;
      lo_hit_q <= 1'b0;
    end else if (st_q == ST_OUT) begin
      lmn_q <= lmn_d;
      a_q <= a_d;
      b_q <= b_d;
      hi_hit_q <= ctrl_q.auto_mode & over_hi;
      lo_hit_q <= ctrl_q.auto_mode & under_lo;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ao0_q <= '0;
      ao1_q <= '0;
    end else begin
      ao0_q <= ao_pick(ctrl_q.ao0_src, a_q, b_q, ain_value);
      ao1_q <= ao_pick(ctrl_q.ao1_src, a_q, b_q, ain_value);
    end
  end

  wire heat_en = (ctrl_q.pmode == PM_TWO) | (ctrl_q.pmode == PM_THREE);
  wire cool_en = ctrl_q.pmode == PM_THREE;

  pidos_pulse u_heat (
    .clk(clk),
    .rst(rst),
    .enable(heat_en),
    .period(pulse_per_q),
    .duty(a_q),
    .pulse(heat_pulse)
  );

  pidos_pulse u_cool (
    .clk(clk),
    .rst(rst),
    .enable(cool_en),
    .period(pulse_per_q),
    .duty(b_q),
    .pulse(cool_pulse)
  );

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign manipulated_value = lmn_q;
  assign out_a = a_q;
  assign out_b = b_q;
  assign ao0 = ao0_q;
  assign ao1 = ao1_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_SEQ: assert property (
    (st_q == ST_IDLE && tick_q) |=> st_q == ST_CALC ##1 st_q == ST_OUT ##1 st_q == ST_IDLE)
    else $error("sample sequence broken");

  AST_LIMIT: assert property (
    (st_q == ST_OUT && lim_lo <= lim_hi)
    |=> (lmn_q <= $past(lim_hi) && lmn_q >= $past(lim_lo)))
    else $error("manipulated value outside limits");

  AST_WINDUP: assert property (
    (st_q == ST_OUT && ctrl_q.auto_mode && !soft_q
     && ((over_hi && inc_q >= 0) || (under_lo && inc_q <= 0)))
    |=> $stable(integ_q))
    else $error("integrator moved while limited");

  AST_UNWIND: assert property (
    (st_q == ST_OUT && ctrl_q.auto_mode && !soft_q && over_hi && inc_q < 0)
    |=> integ_q == $past(integ_q) + $past(inc_q))
    else $error("integrator held against an inward step");

  AST_DEADBAND: assert property (
    (st_q == ST_IDLE && tick_q && !soft_q && err_x <= band && err_x >= -band)
    |=> e_q == '0)
    else $error("error inside band not zeroed");

  AST_PSEL: assert property (
    (st_q == ST_CALC && !ctrl_q.p_sel && !soft_q) |=> p_q == '0)
    else $error("proportional term active while off");

  AST_DOFF: assert property (
    (st_q == ST_CALC && kd_q == '0 && !soft_q) |=> d_q == '0)
    else $error("derivative term active with zero coefficient");

  AST_TRACK: assert property (
    (st_q == ST_OUT && !ctrl_q.auto_mode && !ctrl_q.bumpless && !soft_q)
    |=> integ_q == (ACC_W'($past(man_val)) <<< ACC_FRAC))
    else $error("integrator not loaded with manual value");

  AST_MANUAL: assert property (
    (st_q == ST_OUT && !ctrl_q.auto_mode) |=> lmn_q == $past(man_val))
    else $error("manual value not passed to output");

  AST_SOFT: assert property (
    soft_q |=> (integ_q == '0 && d_q == '0 && e_q == '0))
    else $error("soft reset left controller state");

  AST_BUS: assert property (
    (req && !wait_q) |=> wait_q)
    else $error("waitrequest low for two cycles");
endmodule // pidos_top

// file: sim/pidos_actuator.sv
// Actuator model: heater and cooler on-time counted over an observation window
`timescale 1ns/1ps
module pidos_actuator (
  // Clock and window clear
  input wire logic clk,
  input wire logic clear,
  // Binary drive from the controller
  input wire logic heat_on,
  input wire logic cool_on,
  // Accumulated on-time in cycles
  output int heat_cyc,
  output int cool_cyc
);
  // Pulse lines carry no handshake, so on-time is all the load ever sees
  always @(posedge clk) begin
    if (clear) begin
      heat_cyc <= 0;
      cool_cyc <= 0;
    end else begin
      heat_cyc <= heat_cyc + int'(heat_on);
      cool_cyc <= cool_cyc + int'(cool_on);
    end
  end
endmodule // pidos_actuator

// file: sim/tb.sv
// Self-checking bench for the PID output stage
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
$display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb;
  import pidos_pkg::*;
  typedef struct {logic [15:0] ctrl, gain, oppt, err, mv;} pidos_row_t;
  localparam int SAMP = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic clr = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] rdata;
  logic signed [15:0] error_signal = 16'h0000;
  logic signed [15:0] ain_value = 16'h1234;
  wire [31:0] readdata;
  wire waitrequest;
  wire signed [15:0] mv, out_a, out_b, ao0, ao1;
  wire heat, cool;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int heat_cyc, cool_cyc;
  // Auto, P on except in the last row, ao0 = A, ao1 = B; band 0x0100, no I or D, fixed operating point
  pidos_row_t rows[8] = '{
    '{16'h0245, 16'h0100, 16'h0000, 16'h0080, 16'h0000},
    '{16'h0245, 16'h0100, 16'h0000, 16'h1100, 16'h1000},
    '{16'h0245, 16'h0200, 16'h0000, 16'h1100, 16'h2000},
    '{16'h0245, 16'h0100, 16'h0000, 16'h6000, 16'h4000},
    '{16'h0245, 16'h0100, 16'h0000, 16'hE000, 16'h0000},
    '{16'h0245, 16'hFF00, 16'h0000, 16'hEF00, 16'h1000},
    '{16'h0245, 16'h0100, 16'h0800, 16'h0000, 16'h0800},
    '{16'h0241, 16'h0100, 16'h0800, 16'h1100, 16'h0800}};

  always #12.5 clk = ~clk;

  pidos_top #(.SAMPLE_CYC_DEF(SAMP), .PULSE_CYC_DEF(100)) dut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .error_signal(error_signal), .ain_value(ain_value), .manipulated_value(mv),
    .out_a(out_a), .out_b(out_b), .ao0(ao0), .ao1(ao1), .heat_pulse(heat),
    .cool_pulse(cool));

  pidos_actuator load (.clk(clk), .clear(clr), .heat_on(heat), .cool_on(cool),
    .heat_cyc(heat_cyc), .cool_cyc(cool_cyc));

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rdata = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic run(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Budget covers every scenario below with wide margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    run(20);
    `CHK("waitrequest in reset", 1'b1, waitrequest)
    rst <= 1'b0;
    bus(1'b0, REG_GAIN, 32'h0000_0000);
    `CHK("GAIN reset", 32'h0000_0100, rdata)
    bus(1'b0, REG_LIMIT, 32'h0000_0000);
    `CHK("LIMIT reset", 32'h4000_0000, rdata)
    bus(1'b0, 8'h80, 32'h0000_0000);
    `CHK("unmapped read", 32'h0000_0000, rdata)
    bus(1'b1, REG_SAMPLE, SAMP);
    bus(1'b1, REG_PERIOD, 32'h0000_0064);
    bus(1'b1, REG_DBAND, 32'h0000_0100);
    foreach (rows[i]) begin
      bus(1'b1, REG_CTRL, {16'h0000, rows[i].ctrl});
      bus(1'b1, REG_GAIN, {16'h0000, rows[i].gain});
      bus(1'b1, REG_OPPT, {16'h0000, rows[i].oppt});
      error_signal <= rows[i].err;
      run(3 * SAMP);
      `CHK("mv", rows[i].mv, mv)
      `CHK("ao0 from A", rows[i].mv, ao0)
      `CHK("ao1 from B", rows[i].mv, ao1)
    end
    // Pure integral into the upper limit, then reverse the error
    bus(1'b1, REG_CTRL, 32'h0000_0641);
    bus(1'b1, REG_DBAND, 32'h0000_0000);
    bus(1'b1, REG_KI, 32'h0000_8000);
    bus(1'b1, REG_LIMIT, 32'h2000_0000);
    error_signal <= 16'h1000;
    run(60 * SAMP);
    `CHK("mv at limit", 16'h2000, mv)
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK("upper limit flag", 1'b1, rdata[1])
    error_signal <= 16'hF000;
    // Trapezoid needs one sample to turn and the held overshoot one more to unwind
    run(5 * SAMP);
    `CHK("leaves limit at once", 1'b1, mv < 16'sh2000)
    // Automatic operating point taken from the manual value
    bus(1'b1, REG_CTRL, 32'h0000_064C);
    bus(1'b1, REG_KI, 32'h0000_0000);
    bus(1'b1, REG_LIMIT, 32'h4000_0000);
    bus(1'b1, REG_MANUAL, 32'h0000_1000);
    error_signal <= 16'h0800;
    run(3 * SAMP);
    `CHK("manual mv", 16'h1000, mv)
    bus(1'b1, REG_CTRL, 32'h0000_024D);
    run(3 * SAMP);
    `CHK("auto op mv", 16'h1800, mv)
    bus(1'b0, REG_LMN, 32'h0000_0000);
    `CHK("MANIPULATED_VALUE register", 16'h1800, rdata[15:0])
    // Three-step pulses: A = 25 %, B = 12.5 % over 100-cycle periods
    bus(1'b1, REG_SPB_IN, 32'h4000_0000);
    bus(1'b1, REG_SPB_MAP, 32'h2000_0000);
    bus(1'b1, REG_CTRL, 32'h0000_02E0);
    run(3 * SAMP + 200);
    `CHK("ao0 from ain", 16'h1234, ao0)
    `CHK("out_a scaled", 16'h1000, out_a)
    `CHK("out_b scaled", 16'h0800, out_b)
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    run(200);
    #1;
    `CHK("heat on-time", 50, heat_cyc)
    `CHK("cool on-time", 24, cool_cyc)
    // Bumpless changeover in two-step mode; a tiny reset coefficient keeps A steady
    bus(1'b1, REG_KI, 32'h0000_0001);
    bus(1'b1, REG_CTRL, 32'h0000_0256);
    run(3 * SAMP);
    bus(1'b1, REG_CTRL, 32'h0000_0257);
    run(3 * SAMP);
    `CHK("bumpless mv", 16'h1000, mv)
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    run(200);
    #1;
    `CHK("two-step heat", 50, heat_cyc)
    `CHK("two-step cool", 0, cool_cyc)
    complete_run();
  end
endmodule // tb
